// *** common/cisbu_pkg.sv ***
package cisbu_pkg;

    // ==========================================================
    // Register map, byte addresses
    localparam logic [7:0] CISBU_CTRL_OFS = 8'h00;
    localparam logic [7:0] CISBU_MASK_OFS = 8'h04;
    localparam logic [7:0] CISBU_STAT_OFS = 8'h08;

    // ==========================================================
    // Restart vectors
    localparam logic [7:0] CISBU_VEC_NMI  = 8'h24;
    localparam logic [7:0] CISBU_VEC_A    = 8'h2c;
    localparam logic [7:0] CISBU_VEC_B    = 8'h34;
    localparam logic [7:0] CISBU_VEC_EDGE = 8'h3c;

    // ==========================================================
    // Mask-set data fields
    localparam int CISBU_MS_MASK_LSB = 0;
    localparam int CISBU_MS_MASK_UPD = 3;
    localparam int CISBU_MS_EDGE_CLR = 4;
    localparam int CISBU_MS_SOUT_VAL = 6;
    localparam int CISBU_MS_SOUT_UPD = 7;

    // Control fields
    localparam int CISBU_CTRL_EN  = 0;
    localparam int CISBU_CTRL_DIS = 1;

    // Request index, highest priority first
    localparam int CISBU_REQ_NMI  = 0;
    localparam int CISBU_REQ_EDGE = 1;
    localparam int CISBU_REQ_B    = 2;
    localparam int CISBU_REQ_A    = 3;
    localparam int CISBU_REQ_GEN  = 4;

    // Reset values and response codes
    localparam logic [2:0] CISBU_MASK_RST = 3'h7;
    localparam logic [1:0] CISBU_RESP_OKAY   = 2'h0;
    localparam logic [1:0] CISBU_RESP_SLVERR = 2'h2;

    // Lowest index wins
    function automatic logic [4:0] cisbu_pick(input logic [4:0] req);
        logic [4:0] g;
        g = 5'h00;
        for (int i = 4; i >= 0; i--) begin
            if (req[i]) begin
                g = 5'h01 << i;
            end
        end
        return g;
    endfunction

endpackage

// *** common/cisbu_reg_if.sv ***
`timescale 1ns/1ps
interface cisbu_reg_if;
    logic        wr_en;
    logic [7:0]  wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        wr_ok;
    logic [7:0]  rd_addr;
    logic [31:0] rd_data;
    logic        rd_ok;

    modport bus  (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                  input  wr_ok, rd_data, rd_ok);
    modport regs (input  wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                  output wr_ok, rd_data, rd_ok);
endinterface

// *** rtl/cisbu_axil_slave.sv ***
`timescale 1ns/1ps
module cisbu_axil_slave
    import cisbu_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    cisbu_reg_if.bus         rif
);
    // ==========================================================
    // Write channel: address and data taken in either order
    logic        aw_got;
    logic        w_got;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    wire         aw_hs = s_axi_awvalid & s_axi_awready;
    wire         w_hs  = s_axi_wvalid & s_axi_wready;
    wire         ar_hs = s_axi_arvalid & s_axi_arready;

    assign rif.wr_en   = aw_got & w_got & ~s_axi_bvalid;
    assign rif.wr_addr = aw_addr;
    assign rif.wr_data = w_data;
    assign rif.wr_strb = w_strb;
    assign rif.rd_addr = s_axi_araddr;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= CISBU_RESP_OKAY;
        end else begin
            if (aw_hs) begin
                aw_got        <= 1'b1;
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_hs) begin
                w_got        <= 1'b1;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (rif.wr_en) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= rif.wr_ok ? CISBU_RESP_OKAY : CISBU_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_got        <= 1'b0;
                w_got         <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Read channel: one read in flight
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= CISBU_RESP_OKAY;
        end else if (ar_hs) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rif.rd_ok ? rif.rd_data : 32'h0000_0000;
            s_axi_rresp   <= rif.rd_ok ? CISBU_RESP_OKAY : CISBU_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule // cisbu_axil_slave

// *** rtl/cisbu_sync.sv ***
`timescale 1ns/1ps
module cisbu_sync #(
    parameter int W = 6
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    // ==========================================================
    // Two-stage synchroniser; first stage feeds only the second
    logic [W-1:0] meta;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule // cisbu_sync

// *** rtl/cisbu_top.sv ***
`timescale 1ns/1ps
module cisbu_top
    import cisbu_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Interrupt sources and serial lines
    input  wire logic        general_irq,
    input  wire logic        restart_a_irq,
    input  wire logic        restart_b_irq,
    input  wire logic        restart_edge_irq,
    input  wire logic        nmi_irq,
    input  wire logic        serial_in_line,
    output logic             serial_out_line,
    // Sequencer side
    input  wire logic        instr_last,
    input  wire logic        mask_set_instr,
    input  wire logic [7:0]  mask_set_data,
    input  wire logic        mask_read_instr,
    input  wire logic        enable_irq_instr,
    input  wire logic        disable_irq_instr,
    output logic [7:0]       mask_read_data,
    output logic             restart_req,
    output logic [7:0]       restart_vector,
    output logic             irq_acknowledge,
    output logic             pc_inc_inhibit,
    // AXI4-Lite
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    // ==========================================================
    // Register bus
    cisbu_reg_if rif ();

    cisbu_axil_slave u_slave (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .rif           (rif)
    );

    // ==========================================================
    // Input synchronisers
    logic [5:0] sync_lvl;

    cisbu_sync #(.W(6)) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in ({serial_in_line, nmi_irq, restart_edge_irq,
                    restart_b_irq, restart_a_irq, general_irq}),
        .sync_out (sync_lvl)
    );

    wire gen_lvl  = sync_lvl[0];
    wire a_lvl    = sync_lvl[1];
    wire b_lvl    = sync_lvl[2];
    wire edge_lvl = sync_lvl[3];
    wire nmi_lvl  = sync_lvl[4];
    wire sin_lvl  = sync_lvl[5];

    // ==========================================================
    // State
    logic       ie;
    logic [2:0] mask;
    logic       edge_pend;
    logic       edge_prev;
    logic       nmi_prev;
    logic       nmi_armed;
    logic [7:0] last_vector;

    // ==========================================================
    // Register decode
    wire sel_ctrl = rif.wr_addr == CISBU_CTRL_OFS;
    wire sel_mask = rif.wr_addr == CISBU_MASK_OFS;
    wire bus_wr   = rif.wr_en & rif.wr_strb[0];
    wire bus_en   = bus_wr & sel_ctrl & rif.wr_data[CISBU_CTRL_EN];
    wire bus_dis  = bus_wr & sel_ctrl & rif.wr_data[CISBU_CTRL_DIS];
    wire bus_ms   = bus_wr & sel_mask;

    assign rif.wr_ok = sel_ctrl | sel_mask;
    assign rif.rd_ok = (rif.rd_addr == CISBU_CTRL_OFS) |
                       (rif.rd_addr == CISBU_MASK_OFS) |
                       (rif.rd_addr == CISBU_STAT_OFS);

    // ==========================================================
    // Mask-set: sequencer port wins over a bus write
    wire       ms_fire = mask_set_instr | bus_ms;
    wire [7:0] ms_data = mask_set_instr ? mask_set_data : rif.wr_data[7:0];
    wire       ms_mupd = ms_fire & ms_data[CISBU_MS_MASK_UPD];
    wire       ms_eclr = ms_fire & ms_data[CISBU_MS_EDGE_CLR];
    wire       ms_supd = ms_fire & ms_data[CISBU_MS_SOUT_UPD];

    wire en_req  = enable_irq_instr | bus_en;
    wire dis_req = disable_irq_instr | bus_dis;

    // ==========================================================
    // Request qualification and priority
    wire edge_rise = edge_lvl & ~edge_prev;
    wire nmi_rise  = nmi_lvl & ~nmi_prev;

    wire [4:0] req_vec;
    assign req_vec[CISBU_REQ_NMI]  = nmi_armed & nmi_lvl;
    assign req_vec[CISBU_REQ_EDGE] = ie & ~mask[2] & edge_pend;
    assign req_vec[CISBU_REQ_B]    = ie & ~mask[1] & b_lvl;
    assign req_vec[CISBU_REQ_A]    = ie & ~mask[0] & a_lvl;
    assign req_vec[CISBU_REQ_GEN]  = ie & gen_lvl;

    // Only the current request set matters, not what is in service
    wire [4:0] pick  = cisbu_pick(req_vec);
    wire [4:0] grant = instr_last ? pick : 5'h00;
    wire       any_grant  = |grant;
    wire       rst_grant  = |grant[CISBU_REQ_A:CISBU_REQ_NMI];

    wire [7:0] grant_vec = grant[CISBU_REQ_NMI]  ? CISBU_VEC_NMI  :
                           grant[CISBU_REQ_EDGE] ? CISBU_VEC_EDGE :
                           grant[CISBU_REQ_B]    ? CISBU_VEC_B    :
                           CISBU_VEC_A;

    // ==========================================================
    // Next-state
    wire next_edge_pend = edge_rise |
                          (edge_pend & ~grant[CISBU_REQ_EDGE] & ~ms_eclr);

    // Held high since the rise; dropping low disarms
    wire next_nmi_armed = nmi_rise |
                          (nmi_armed & nmi_lvl & ~grant[CISBU_REQ_NMI]);

    // Service clear wins over an enable in the same cycle
    wire next_ie = any_grant ? 1'b0 :
                   en_req    ? 1'b1 :
                   dis_req   ? 1'b0 : ie;

    wire [7:0] read_word = {sin_lvl, edge_pend, b_lvl, a_lvl,
                            ie, mask};

    // ==========================================================
    // Interrupt state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ie        <= 1'b0;
            mask      <= CISBU_MASK_RST;
            edge_pend <= 1'b0;
            edge_prev <= 1'b0;
            nmi_prev  <= 1'b0;
            nmi_armed <= 1'b0;
        end else begin
            ie        <= next_ie;
            edge_pend <= next_edge_pend;
            edge_prev <= edge_lvl;
            nmi_prev  <= nmi_lvl;
            nmi_armed <= next_nmi_armed;
            if (ms_mupd) begin
                mask <= ms_data[CISBU_MS_MASK_LSB +: 3];
            end
        end
    end

    // ==========================================================
    // Sequencer outputs: one-cycle pulses, restart_vector held until the next restart
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            restart_req     <= 1'b0;
            restart_vector  <= 8'h00;
            irq_acknowledge <= 1'b0;
            pc_inc_inhibit  <= 1'b0;
            last_vector     <= 8'h00;
        end else begin
            restart_req     <= rst_grant;
            irq_acknowledge <= grant[CISBU_REQ_GEN];
            pc_inc_inhibit  <= grant[CISBU_REQ_GEN];
            if (rst_grant) begin
                restart_vector <= grant_vec;
                last_vector    <= grant_vec;
            end
        end
    end

    // ==========================================================
    // Serial bits and mask-read capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            serial_out_line <= 1'b0;
            mask_read_data  <= 8'h00;
        end else begin
            if (ms_supd) begin
                serial_out_line <= ms_data[CISBU_MS_SOUT_VAL];
            end
            if (mask_read_instr) begin
                mask_read_data <= read_word;
            end
        end
    end

    // ==========================================================
    // Bus read mux
    assign rif.rd_data = (rif.rd_addr == CISBU_CTRL_OFS) ? {31'h0, ie} :
                         (rif.rd_addr == CISBU_MASK_OFS) ? {24'h0, read_word} :
                         {16'h0, last_vector, 3'h0, req_vec};
endmodule // cisbu_top

// *** test/cisbu_seq_model.sv ***
`timescale 1ns/1ps
module cisbu_seq_model
    import cisbu_pkg::*;
#(
    parameter int PERIOD = 3
) (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       restart_req,
    input  wire logic [7:0] restart_vector,
    input  wire logic       irq_acknowledge,
    output logic            instr_last = 1'b0,
    output logic [7:0]      svc_vec,
    output logic [7:0]      svc_cnt
);
    // ==========================================
    // Instruction end every PERIOD cycles; a larger PERIOD is a slow core
    int phase;
    always @(posedge aclk) begin
        if (!aresetn) begin
            phase <= 0;
            instr_last <= 1'b0;
            svc_cnt <= 8'h00;
            svc_vec <= 8'h00;
        end else begin
            phase <= (phase + 1) % PERIOD;
            instr_last <= (phase == 0);
            // Acknowledge logged as ff, vector comes from outside
            if (irq_acknowledge || restart_req) begin
                svc_cnt <= svc_cnt + 8'h01;
                svc_vec <= irq_acknowledge ? 8'hff : restart_vector;
            end
        end
    end
endmodule // cisbu_seq_model

// *** test/cisbu_top_chk.sv ***
`timescale 1ns/1ps
module cisbu_top_chk
    import cisbu_pkg::*;
(
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       general_irq,
    input wire logic       restart_a_irq,
    input wire logic       restart_b_irq,
    input wire logic       nmi_irq,
    input wire logic       serial_in_line,
    input wire logic       instr_last,
    input wire logic       mask_read_instr,
    input wire logic       enable_irq_instr,
    input wire logic [7:0] mask_read_data,
    input wire logic       restart_req,
    input wire logic [7:0] restart_vector,
    input wire logic       irq_acknowledge,
    input wire logic       pc_inc_inhibit
);
    // ==========================================
    // Enable instruction pulsed at least once since reset
    logic ever_en;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ever_en <= 1'b0;
        end else if (enable_irq_instr) begin
            ever_en <= 1'b1;
        end
    end

    // ==========================================
    // Properties
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_svc;
        restart_req || irq_acknowledge;
    endsequence
    sequence s_svc_no_en;
        s_svc ##0 !enable_irq_instr;
    endsequence
    property p_vec; restart_req |-> restart_vector inside {8'h24, 8'h2c, 8'h34, 8'h3c}; endproperty
    a_vec: assert property (p_vec) else $error("bad restart vector");
    property p_one; s_svc |=> !(restart_req || irq_acknowledge); endproperty
    a_one: assert property (p_one) else $error("service pulse too long");
    property p_cause; s_svc |-> $past(instr_last); endproperty
    a_cause: assert property (p_cause) else $error("service outside last cycle");
    property p_ack; irq_acknowledge |-> pc_inc_inhibit && !restart_req && $past(general_irq, 3); endproperty
    a_ack: assert property (p_ack) else $error("bad acknowledge");
    property p_rst_ie; irq_acknowledge |-> $past(ever_en); endproperty
    a_rst_ie: assert property (p_rst_ie) else $error("served with enable off");
    property p_block; s_svc_no_en |-> ##2 !(irq_acknowledge || (restart_req && restart_vector != CISBU_VEC_NMI)); endproperty
    a_block: assert property (p_block) else $error("served after service");
    property p_nmi; restart_req && restart_vector == CISBU_VEC_NMI |-> $past(nmi_irq, 3); endproperty
    a_nmi: assert property (p_nmi) else $error("nmi restart without input");
    property p_lvl_a; restart_req && restart_vector == CISBU_VEC_A |-> $past(restart_a_irq, 3); endproperty
    a_lvl_a: assert property (p_lvl_a) else $error("restart A without level");
    property p_lvl_b; restart_req && restart_vector == CISBU_VEC_B |-> $past(restart_b_irq, 3); endproperty
    a_lvl_b: assert property (p_lvl_b) else $error("restart B without level");
    property p_sin; mask_read_instr |=> mask_read_data[7] == $past(serial_in_line, 3); endproperty
    a_sin: assert property (p_sin) else $error("serial in not in read bit 7");
endmodule // cisbu_top_chk

bind cisbu_top cisbu_top_chk u_chk (.aclk, .aresetn, .general_irq, .restart_a_irq,
    .restart_b_irq, .nmi_irq, .serial_in_line, .instr_last, .mask_read_instr, .enable_irq_instr,
    .mask_read_data, .restart_req, .restart_vector, .irq_acknowledge, .pc_inc_inhibit);

// *** test/cisbu_top_tb.sv ***
`timescale 1ns/1ps
module cisbu_top_tb
    import cisbu_pkg::*;
;
    typedef struct packed {
        logic [2:0] mask;
        logic       en;
        logic [4:0] req;
        logic [7:0] vec;
    } cisbu_row_t;

    // ==========================================
    // Signals
    logic        aclk, aresetn, general_irq, restart_a_irq, restart_b_irq, restart_edge_irq;
    logic        nmi_irq, serial_in_line, serial_out_line, instr_last, mask_set_instr;
    logic        mask_read_instr, enable_irq_instr, disable_irq_instr, restart_req;
    logic        irq_acknowledge, pc_inc_inhibit, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [7:0]  mask_set_data, mask_read_data, restart_vector, s_axi_awaddr, s_axi_araddr;
    logic [7:0]  svc_vec, svc_cnt, c0;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          errors, cmp_count, cycles;
    cisbu_row_t  rows [9] = '{
        '{3'h0, 1'b0, 5'h1f, 8'h24}, '{3'h0, 1'b1, 5'h0f, 8'h3c}, '{3'h0, 1'b1, 5'h07, 8'h34},
        '{3'h0, 1'b1, 5'h03, 8'h2c}, '{3'h0, 1'b1, 5'h01, 8'hff}, '{3'h7, 1'b1, 5'h0f, 8'hff},
        '{3'h0, 1'b0, 5'h07, 8'h00}, '{3'h6, 1'b1, 5'h0f, 8'h2c}, '{3'h3, 1'b1, 5'h0f, 8'h3c}};

    cisbu_top dut (.aclk, .aresetn, .general_irq, .restart_a_irq, .restart_b_irq,
        .restart_edge_irq, .nmi_irq, .serial_in_line, .serial_out_line, .instr_last,
        .mask_set_instr, .mask_set_data, .mask_read_instr, .enable_irq_instr, .disable_irq_instr,
        .mask_read_data, .restart_req, .restart_vector, .irq_acknowledge, .pc_inc_inhibit,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    cisbu_seq_model #(.PERIOD(3)) seq (.aclk, .aresetn, .restart_req, .restart_vector,
        .irq_acknowledge, .instr_last, .svc_vec, .svc_cnt);

    // ==========================================
    // Tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic ms(input logic [7:0] d);
        mask_set_data <= d;
        mask_set_instr <= 1'b1;
        @(posedge aclk);
        mask_set_instr <= 1'b0;
    endtask
    task automatic en_pulse();
        enable_irq_instr <= 1'b1;
        @(posedge aclk);
        enable_irq_instr <= 1'b0;
    endtask
    // Vector of the first service since count c, 00 when none came
    task automatic wait_svc(input logic [7:0] c, input logic [7:0] exp);
        repeat (30) begin
            @(posedge aclk);
            if (svc_cnt !== c) break;
        end
        chk({24'h0, (svc_cnt !== c) ? svc_vec : 8'h00}, {24'h0, exp});
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic done;
        done = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                done = 1'b1;
                chk({30'h0, s_axi_bresp}, {30'h0, r});
            end
        end
    endtask
    task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic done;
        done = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                done = 1'b1;
                chk(s_axi_rdata, d);
                chk({30'h0, s_axi_rresp}, {30'h0, r});
            end
        end
    endtask

    // ==========================================
    // Clock and timeout, run needs about 400 cycles
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 6000) begin
            errors++;
            stop_test();
        end
    end

    // ==========================================
    // Sequence
    initial begin
        {aresetn, general_irq, restart_a_irq, restart_b_irq, restart_edge_irq, nmi_irq} = '0;
        {serial_in_line, mask_set_instr, mask_read_instr, enable_irq_instr} = '0;
        {disable_irq_instr, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, mask_set_data, s_axi_awaddr, s_axi_araddr} = '0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axr(CISBU_CTRL_OFS, 32'h0, CISBU_RESP_OKAY);
        axr(CISBU_MASK_OFS, 32'h7, CISBU_RESP_OKAY);
        // Inputs raised with enable off so the edge flop has settled first
        foreach (rows[i]) begin
            ms(8'h18 | {5'h0, rows[i].mask});
            c0 = svc_cnt;
            {nmi_irq, restart_edge_irq, restart_b_irq, restart_a_irq, general_irq} <= rows[i].req;
            cyc(8);
            if (rows[i].en) en_pulse();
            wait_svc(c0, rows[i].vec);
            {nmi_irq, restart_edge_irq, restart_b_irq, restart_a_irq, general_irq} <= 5'h0;
            disable_irq_instr <= 1'b1;
            cyc(1);
            disable_irq_instr <= 1'b0;
            cyc(4);
        end
        $display("priority table done");
        ms(8'h1c);
        restart_edge_irq <= 1'b1;
        cyc(1);
        restart_edge_irq <= 1'b0;
        cyc(6);
        c0 = svc_cnt;
        ms(8'h08);
        en_pulse();
        wait_svc(c0, CISBU_VEC_EDGE);
        c0 = svc_cnt;
        en_pulse();
        wait_svc(c0, 8'h00);
        ms(8'h1c);
        restart_edge_irq <= 1'b1;
        cyc(1);
        restart_edge_irq <= 1'b0;
        cyc(6);
        ms(8'h18);
        c0 = svc_cnt;
        wait_svc(c0, 8'h00);
        $display("edge request done");
        ms(8'h0f);
        c0 = svc_cnt;
        nmi_irq <= 1'b1;
        wait_svc(c0, CISBU_VEC_NMI);
        c0 = svc_cnt;
        wait_svc(c0, 8'h00);
        nmi_irq <= 1'b0;
        cyc(4);
        nmi_irq <= 1'b1;
        wait_svc(c0, CISBU_VEC_NMI);
        nmi_irq <= 1'b0;
        $display("nmi done");
        ms(8'h08);
        {restart_b_irq, restart_a_irq} <= 2'h3;
        cyc(6);
        c0 = svc_cnt;
        en_pulse();
        wait_svc(c0, CISBU_VEC_B);
        restart_b_irq <= 1'b0;
        axr(CISBU_CTRL_OFS, 32'h0, CISBU_RESP_OKAY);
        c0 = svc_cnt;
        en_pulse();
        wait_svc(c0, CISBU_VEC_A);
        restart_a_irq <= 1'b0;
        $display("nesting done");
        axr(CISBU_STAT_OFS, 32'h2c00, CISBU_RESP_OKAY);
        serial_in_line <= 1'b1;
        ms(8'hc0);
        cyc(4);
        chk({31'h0, serial_out_line}, 32'h1);
        mask_read_instr <= 1'b1;
        cyc(1);
        mask_read_instr <= 1'b0;
        cyc(1);
        chk({24'h0, mask_read_data}, 32'h80);
        axw(CISBU_MASK_OFS, 32'h0f, CISBU_RESP_OKAY);
        axr(CISBU_MASK_OFS, 32'h87, CISBU_RESP_OKAY);
        axw(CISBU_CTRL_OFS, 32'h1, CISBU_RESP_OKAY);
        axr(CISBU_CTRL_OFS, 32'h1, CISBU_RESP_OKAY);
        axw(CISBU_CTRL_OFS, 32'h2, CISBU_RESP_OKAY);
        axr(CISBU_CTRL_OFS, 32'h0, CISBU_RESP_OKAY);
        axw(CISBU_MASK_OFS, 32'h80, CISBU_RESP_OKAY);
        cyc(2);
        chk({31'h0, serial_out_line}, 32'h0);
        axw(CISBU_STAT_OFS, 32'h0, CISBU_RESP_SLVERR);
        axr(8'h0c, 32'h0, CISBU_RESP_SLVERR);
        $display("serial and bus done");
        serial_in_line <= 1'b0;
        ms(8'hc8);
        en_pulse();
        cyc(4);
        chk({31'h0, serial_out_line}, 32'h1);
        aresetn <= 1'b0;
        cyc(2);
        aresetn <= 1'b1;
        cyc(1);
        axr(CISBU_CTRL_OFS, 32'h0, CISBU_RESP_OKAY);
        axr(CISBU_MASK_OFS, 32'h7, CISBU_RESP_OKAY);
        chk({31'h0, serial_out_line}, 32'h0);
        $display("reset done");
        stop_test();
    end
endmodule // cisbu_top_tb
